// File: design/hbs_sequencer.sv
// Overview of operation
// R01: a software or peripheral trigger starts scanning its associated scan group
// R02: scan start sets the group active flag of that group, groups zero to eight
// R03: scan start sets the converter active flag of the selected converter unit
// R04: move to the next channel after every single oversample, rotating
// R05: first result needs tap count times addition or averaging count oversamples
// R06: no result is obtainable before the initial delay from scan start
// R07: later rounds keep the filter history instead of clearing it
// R08: after the initial delay every oversample updates the channel filter
// R09: a fresh result follows every oversample or every averaging group
// R10: after the initial delay results refresh once per group delay period
// R11: trigger while scanning copies newest filtered results into result registers
// R12: with fifo enabled the results also go to the group fifo register
// R13: after storing, raise the scan end interrupt if enabled
// R14: scanning repeats until stopped, each trigger stores again
// R15: software ends scanning only through the forced stop command
// R16: software keeps the digital filter enabled in hybrid mode
// R17: forced stop clears group active and converter active flags
// R18: a trigger before the initial delay stores nothing
`timescale 1ns/1ps
`default_nettype none
`include "hbs_regs.svh"

module hbs_sequencer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [8:0]  periph_trig,
    output logic             conv_req,
    output logic [4:0]       conv_channel,
    output logic             conv_unit,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             irq
);

    // ------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------
    // pready high marks the answer cycle, which must not count as a new access
    wire        acc_phase = psel & penable & ~pready;
    wire        wr_acc    = acc_phase & pwrite;
    wire [9:0]  widx      = paddr[11:2];
    wire        hit_ctrl  = paddr == `HBS_OFS_CTRL;
    wire        hit_cmd   = paddr == `HBS_OFS_CMD;
    wire        hit_state = paddr == `HBS_OFS_STATE;
    wire        hit_stat  = paddr == `HBS_OFS_IRQ_STAT;
    wire        hit_mask  = paddr == `HBS_OFS_IRQ_MASK;
    wire        hit_ext   = paddr == `HBS_OFS_EXT;
    // addresses below a window base wrap to large offsets and miss it
    wire [9:0]  res_rel   = 10'(widx - `HBS_OFS_RES_BASE / 4);
    wire [9:0]  fifo_rel  = 10'(widx - `HBS_OFS_FIFO_BASE / 4);
    wire        hit_res   = (paddr[1:0] == 2'h0) && (res_rel < `HBS_NVC);
    wire        hit_fifo  = (paddr[1:0] == 2'h0) && (fifo_rel < `HBS_NGRP);
    wire        mapped    = hit_ctrl | hit_cmd | hit_state | hit_stat | hit_mask
                          | hit_ext | hit_res | hit_fifo;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [6:0] ctrl;
    logic [1:0] irq_mask;
    logic [1:0] irq_stat;

    wire        fifo_en   = ctrl[`HBS_CTRL_FIFO_EN];
    wire        avg_mode  = ctrl[`HBS_CTRL_AVG_MODE];
    wire [1:0]  avg_code  = ctrl[`HBS_CTRL_AVG_HI:`HBS_CTRL_AVG_LO];
    wire        unit_sel  = ctrl[`HBS_CTRL_UNIT];
    wire [1:0]  chan_last = ctrl[`HBS_CTRL_LAST_HI:`HBS_CTRL_LAST_LO];
    wire [3:0]  avg_last  = 4'((4'h1 << avg_code) - 4'h1);

    wire        cmd_wr    = wr_acc & hit_cmd;
    wire        sw_trig   = cmd_wr & pwdata[`HBS_CMD_SW_TRIG];
    wire [3:0]  sw_group  = pwdata[`HBS_CMD_GRP_HI:`HBS_CMD_GRP_LO];
    wire        force_stop = cmd_wr & pwdata[`HBS_CMD_STOP];

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl     <= `HBS_CTRL_RST;
            irq_mask <= `HBS_MASK_RST;
        end else if (wr_acc) begin
            if (hit_ctrl)
                ctrl <= pwdata[6:0];
            if (hit_mask)
                irq_mask <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // scan control
    // ------------------------------------------------------------
    hbs_pkg::hbs_state_e state;
    hbs_pkg::hbs_state_e next_state;
    logic [8:0] group_active_flag;
    logic [1:0] converter_active_flag;
    logic [3:0] act_group;
    logic [1:0] vc;
    logic       scanning;

    // lowest peripheral index wins when several fire in one cycle
    function automatic logic [3:0] first_trig(input logic [8:0] t);
        logic [3:0] r;
        r = 4'h0;
        for (int i = `HBS_NGRP - 1; i >= 0; i--) begin
            if (t[i])
                r = 4'(i);
        end
        return r;
    endfunction : first_trig

    wire        valid_sw  = sw_trig && (sw_group < `HBS_NGRP);
    wire        any_trig  = valid_sw | (|periph_trig);
    wire [3:0]  trig_grp  = valid_sw ? sw_group : first_trig(periph_trig);
    // new scan only when idle; a running scan ignores triggers for other groups
    wire        start_scan = any_trig & ~scanning & ~force_stop;                 // R01
    wire        own_trig   = scanning & ~force_stop
                           & ((valid_sw & (sw_group == act_group)) | periph_trig[act_group]);
    // a done pulse outside the wait state is stale, e.g. after a stop
    wire        sample_in  = (state == hbs_pkg::HBS_WAIT) & conv_done;
    // the last channel code restarts the rotation at zero; a code above it counts up and wraps to zero after 3
    wire [1:0]  vc_next    = (vc == chan_last) ? 2'h0 : 2'(vc + 2'h1);

    // a stop overrides every transition so no further request reaches the core
    always_comb begin
        next_state = state;
        case (state)
            hbs_pkg::HBS_IDLE: begin
                if (start_scan)
                    next_state = hbs_pkg::HBS_REQ;
            end
            hbs_pkg::HBS_REQ: begin
                next_state = hbs_pkg::HBS_WAIT;
            end
            hbs_pkg::HBS_WAIT: begin
                if (conv_done)
                    next_state = hbs_pkg::HBS_REQ;
            end
            default: begin
                next_state = hbs_pkg::HBS_IDLE;
            end
        endcase
        if (force_stop)
            next_state = hbs_pkg::HBS_IDLE;                                      // R15
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state                 <= hbs_pkg::HBS_IDLE;
            scanning              <= 1'b0;
            act_group             <= 4'h0;
            vc                    <= 2'h0;
            group_active_flag     <= 9'h000;
            converter_active_flag <= 2'h0;
            conv_req              <= 1'b0;
            conv_channel          <= 5'h00;
            conv_unit             <= 1'b0;
        end else begin
            state    <= next_state;
            conv_req <= (next_state == hbs_pkg::HBS_REQ);
            if (force_stop) begin
                scanning              <= 1'b0;                                   // R17
                group_active_flag     <= 9'h000;                                 // R17
                converter_active_flag <= 2'h0;                                   // R17
            end else if (start_scan) begin
                scanning  <= 1'b1;
                act_group <= trig_grp;
                vc        <= 2'h0;
                conv_channel <= 5'h00;
                conv_unit <= unit_sel;
                group_active_flag     <= 9'(9'h001 << trig_grp);                 // R02
                converter_active_flag <= 2'(2'h1 << unit_sel);                   // R03
            end else if (sample_in) begin
                vc           <= vc_next;                                         // R04
                conv_channel <= 5'(vc_next);                                     // R04
            end
        end
    end

    // ------------------------------------------------------------
    // per channel digital filter
    // ------------------------------------------------------------
    // history is wiped only on reset, a new scan or a stop, never between rounds
    wire clr_filter = rst | start_scan | force_stop;

    hbs_pkg::hbs_result_t filt [`HBS_NVC];
    logic [`HBS_NVC-1:0] chan_ready;

    for (genvar g = 0; g < `HBS_NVC; g++) begin : g_chan
        // eight full-scale samples fit the accumulator, four taps of them the sum
        hbs_pkg::hbs_acc_t acc;
        hbs_pkg::hbs_acc_t hist [`HBS_TAPS];
        logic [16:0] sum;
        logic [3:0]  sub;
        logic [2:0]  fill;
        wire         hit   = sample_in & (vc == 2'(g));
        wire         done  = hit & (sub == avg_last);
        wire [14:0]  nval  = 15'(acc + 15'(conv_data));
        wire [16:0]  tap_avg = sum >> `HBS_TAP_SHIFT;

        always_ff @(posedge clock) begin
            if (clr_filter) begin
                acc  <= 15'h0000;
                sub  <= 4'h0;
                fill <= 3'h0;
                sum  <= 17'h00000;
                for (int t = 0; t < `HBS_TAPS; t++)
                    hist[t] <= 15'h0000;
            end else if (done) begin
                // a full averaging group enters the tap line
                acc  <= 15'h0000;                                                // R09
                sub  <= 4'h0;
                sum  <= 17'(sum - 17'(hist[`HBS_TAPS-1]) + 17'(nval));           // R08
                hist[0] <= nval;
                for (int t = 1; t < `HBS_TAPS; t++)
                    hist[t] <= hist[t-1];                                        // R07
                // saturates so readiness never drops while the scan runs
                if (fill != 3'(`HBS_TAPS))
                    fill <= 3'(fill + 3'h1);                                     // R05
            end else if (hit) begin
                acc <= nval;                                                     // R08
                sub <= 4'(sub + 4'h1);
            end
        end

        // channels past the last one never hold the group back
        assign chan_ready[g] = (fill == 3'(`HBS_TAPS)) | (2'(g) > chan_last);    // R05
        assign filt[g] = avg_mode ? 16'(tap_avg >> avg_code) : 16'(tap_avg);     // R10
    end

    // initial delay is over once every channel in the group holds a full tap line
    wire all_ready = &chan_ready;                                                // R06

    // ------------------------------------------------------------
    // result store walk
    // ------------------------------------------------------------
    hbs_pkg::hbs_result_t res_reg [`HBS_NVC];
    hbs_pkg::hbs_result_t fifo_reg [`HBS_NGRP];
    logic [31:0] ext_reg;
    logic        st_busy;
    logic [1:0]  st_idx;
    logic [3:0]  st_grp;
    // a trigger during a walk is absorbed: the walk already holds fresh data
    wire         store_go  = own_trig & all_ready & ~st_busy;                    // R11
    // early triggers are flagged so software can tell a lost store from a slow one
    wire         early     = own_trig & ~all_ready;                              // R18
    wire         st_last   = st_busy & (st_idx == chan_last);

    // one channel per cycle keeps a single read port on the filter outputs
    always_ff @(posedge clock) begin
        if (rst | force_stop) begin
            st_busy <= 1'b0;
            st_idx  <= 2'h0;
            st_grp  <= 4'h0;
        end else if (store_go) begin
            st_busy <= 1'b1;                                                     // R14
            st_idx  <= 2'h0;
            st_grp  <= act_group;
        end else if (st_busy) begin
            st_busy <= ~st_last;
            st_idx  <= 2'(st_idx + 2'h1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < `HBS_NVC; i++)
                res_reg[i] <= 16'h0000;
            for (int k = 0; k < `HBS_NGRP; k++)
                fifo_reg[k] <= 16'h0000;
            ext_reg <= 32'h00000000;
        end else if (st_busy) begin
            res_reg[st_idx] <= filt[st_idx];                                     // R11
            if (fifo_en)
                fifo_reg[st_grp] <= filt[st_idx];                                // R12
            // the extended word tags the last result with its group
            if (st_last)
                ext_reg <= {12'h000, st_grp, filt[st_idx]};                      // R11
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    wire [1:0] stat_set = {early, st_last};                                      // R13
    wire [1:0] stat_clr = (wr_acc & hit_stat) ? pwdata[1:0] : 2'h0;
    wire [1:0] stat_next = (irq_stat & ~stat_clr) | stat_set;

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat <= 2'h0;
            irq      <= 1'b0;
        end else begin
            // a new event in the clear cycle survives the clear
            irq_stat <= stat_next;
            irq      <= |(stat_next & irq_mask);                                 // R13
        end
    end

    // ------------------------------------------------------------
    // apb read data and answer
    // ------------------------------------------------------------
    wire [31:0] state_word = {7'h00, all_ready, 6'h00, converter_active_flag,
                              7'h00, group_active_flag};
    wire [31:0] ctrl_word = {25'h0000000, ctrl};
    wire [31:0] stat_word = {30'h00000000, irq_stat};
    wire [31:0] mask_word = {30'h00000000, irq_mask};
    wire [31:0] res_word  = {16'h0000, res_reg[res_rel[1:0]]};
    wire [31:0] fifo_word = {16'h0000, fifo_reg[fifo_rel[3:0]]};
    wire [31:0] rd_mux =
        hit_ctrl  ? ctrl_word :
        hit_state ? state_word :
        hit_stat  ? stat_word :
        hit_mask  ? mask_word :
        hit_ext   ? ext_reg :
        hit_res   ? res_word :
        hit_fifo  ? fifo_word :
        32'h00000000;

    // one wait state so that read data leaves a flip-flop
    always_ff @(posedge clock) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= acc_phase;
            pslverr <= acc_phase & ~mapped;
            prdata  <= (acc_phase & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

endmodule : hbs_sequencer
`default_nettype wire

// File: design/hbs_regs.svh
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define HBS_OFS_CTRL      12'h000
`define HBS_OFS_CMD       12'h004
`define HBS_OFS_STATE     12'h008
`define HBS_OFS_IRQ_STAT  12'h00C
`define HBS_OFS_IRQ_MASK  12'h010
`define HBS_OFS_EXT       12'h014
`define HBS_OFS_RES_BASE  12'h020
`define HBS_OFS_FIFO_BASE 12'h040

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define HBS_CTRL_FIFO_EN  0
`define HBS_CTRL_AVG_MODE 1
`define HBS_CTRL_AVG_LO   2
`define HBS_CTRL_AVG_HI   3
`define HBS_CTRL_UNIT     4
`define HBS_CTRL_LAST_LO  5
`define HBS_CTRL_LAST_HI  6
`define HBS_CMD_SW_TRIG   0
`define HBS_CMD_GRP_LO    4
`define HBS_CMD_GRP_HI    7
`define HBS_CMD_STOP      8
`define HBS_ST_CONV_LO    16
`define HBS_ST_READY      24
`define HBS_IRQ_SCAN_END  0
`define HBS_IRQ_EARLY     1

// ------------------------------------------------------------
// sizes and reset values
// ------------------------------------------------------------
`define HBS_NGRP          9
`define HBS_NVC           4
`define HBS_TAPS          4
`define HBS_TAP_SHIFT     2
`define HBS_CTRL_RST      7'h00
`define HBS_MASK_RST      2'h0

`endif

// File: design/hbs_pkg.sv
package hbs_pkg;

    // conversion request sequencing towards the converter core
    typedef enum logic [1:0] {
        HBS_IDLE,
        HBS_REQ,
        HBS_WAIT
    } hbs_state_e;

    typedef logic [11:0] hbs_sample_t;
    typedef logic [14:0] hbs_acc_t;
    typedef logic [15:0] hbs_result_t;

endpackage : hbs_pkg

// File: verif/hbs_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbs_regs.svh"

module hbs_sequencer_asserts (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [8:0]  periph_trig,
    input wire logic        conv_req,
    input wire logic [4:0]  conv_channel,
    input wire logic        conv_unit,
    input wire logic        conv_done,
    input wire logic [11:0] conv_data,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // helper state rebuilt from the bus traffic
    // ------------------------------------------------------------
    logic       pending;
    logic [4:0] prev_ch;
    logic [1:0] mask_q;
    wire logic  take = psel && penable && !pready && pwrite;
    wire logic  stop_take = take && paddr == `HBS_OFS_CMD && pwdata[`HBS_CMD_STOP];

    always_ff @(posedge clock) begin
        if (rst || stop_take || conv_done) pending <= 1'b0;
        else if (conv_req) pending <= 1'b1;
        if (rst) prev_ch <= 5'h00;
        else if (conv_req) prev_ch <= conv_channel;
        if (rst) mask_q <= 2'h0;
        else if (take && paddr == `HBS_OFS_IRQ_MASK) mask_q <= pwdata[1:0];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // a stop taken at the same edge sends the sequencer idle instead
    sequence s_sample_back;
        pending && conv_done && !stop_take;
    endsequence

    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside an answer");
    a_req_pulse: assert property (conv_req |=> !conv_req)
        else $error("conv_req longer than one cycle");
    a_one_pending: assert property (pending |-> !conv_req)
        else $error("second conv_req while one is pending");
    a_sample_next: assert property (s_sample_back |=> conv_req)
        else $error("no conv_req in the cycle after conv_done");
    a_chan_rotate: assert property (conv_req |-> conv_channel < 5'h04 &&
        (conv_channel == 5'h00 || conv_channel == prev_ch + 5'h01))
        else $error("channel did not rotate");
    a_mask_quiet: assert property (mask_q == 2'h0 [*2] |-> !irq)
        else $error("irq high with all sources masked");
endmodule : hbs_sequencer_asserts

bind hbs_sequencer hbs_sequencer_asserts hbs_sequencer_asserts_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_trig(periph_trig), .conv_req(conv_req),
    .conv_channel(conv_channel), .conv_unit(conv_unit), .conv_done(conv_done),
    .conv_data(conv_data), .irq(irq)
);
`default_nettype wire

// File: verif/hbs_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module hbs_core_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        conv_req,
    input  wire logic [4:0]  conv_channel,
    input  wire logic [11:0] base,
    output logic             conv_done,
    output logic      [11:0] conv_data,
    output int               samples
);
    // ------------------------------------------------------------
    // one oversample per request, after a random 1 to 4 cycle delay
    // ------------------------------------------------------------
    int         mseed = 32'h0000E6E5;
    logic       pend = 1'b0;
    logic [1:0] dly;
    logic [4:0] ch;

    always @(posedge clock) begin
        conv_done <= 1'b0;
        // data lines carry nothing outside the done pulse, so keep them moving
        conv_data <= ~conv_data;
        if (rst) begin
            pend      <= 1'b0;
            conv_data <= 12'h000;
            samples   <= 0;
        end else if (conv_req) begin
            pend <= 1'b1;
            ch <= conv_channel;
            dly <= 2'($random(mseed));
        end else if (pend && dly != 2'h0) begin
            dly <= dly - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= base + {7'h00, ch};
            samples <= samples + 1;
        end
    end
endmodule : hbs_core_model
`default_nettype wire

// File: verif/tb_hbs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbs_regs.svh"

module tb_hbs_sequencer;
    logic        clock, rst, psel, penable, pwrite, perr;
    logic [11:0] paddr, base;
    logic [31:0] pwdata, prdata, q, ctrl, e;
    logic        pready, pslverr, conv_req, conv_unit, conv_done, irq;
    logic [8:0]  periph_trig;
    logic [4:0]  conv_channel;
    logic [11:0] conv_data;
    logic [3:0]  g;
    logic [1:0]  m;
    int          err_total = 0, comparisons = 0, cyc = 0;
    int          seed, samples, s0, nch, cnt, n, r, c;

    hbs_sequencer hbs_sequencer_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_trig(periph_trig), .conv_req(conv_req),
        .conv_channel(conv_channel), .conv_unit(conv_unit), .conv_done(conv_done),
        .conv_data(conv_data), .irq(irq));
    hbs_core_model hbs_core_model_i (.clock(clock), .rst(rst), .conv_req(conv_req),
        .conv_channel(conv_channel), .base(base), .conv_done(conv_done),
        .conv_data(conv_data), .samples(samples));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // bus, compare and expectation helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    function automatic logic [31:0] exp_res(input int ch);
        logic [15:0] v;
        v = {4'h0, base + 12'(ch)};
        return ctrl[1] ? {16'h0, v} : {16'h0, v << ctrl[3:2]};
    endfunction : exp_res

    task automatic check_store();
        apb(1'b1, `HBS_OFS_CMD, {24'h0, g, 4'h1});
        n = 0;
        do begin
            apb(1'b0, `HBS_OFS_IRQ_STAT, 32'h0);
            n++;
        end while (q[0] !== 1'b1 && n < 20);
        chk(q, 32'h1);
        chk({31'h0, irq}, {31'h0, m[0]});
        for (c = 0; c < nch; c++) begin
            apb(1'b0, `HBS_OFS_RES_BASE + 12'(4 * c), 32'h0);
            chk(q, exp_res(c));
        end
        e = exp_res(nch - 1);
        apb(1'b0, `HBS_OFS_EXT, 32'h0);
        chk(q, {12'h0, g, e[15:0]});
        if (ctrl[0]) begin
            apb(1'b0, `HBS_OFS_FIFO_BASE + 12'(4 * g), 32'h0);
            chk(q, e);
        end
        apb(1'b1, `HBS_OFS_IRQ_STAT, 32'h3);
        apb(1'b0, `HBS_OFS_IRQ_STAT, 32'h0);
        chk({q[31:1], irq}, 32'h0);
    endtask : check_store

    task automatic wrap_up();
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h0000E6E5;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {periph_trig, base, ctrl, m} = 55'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, `HBS_OFS_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `HBS_OFS_IRQ_MASK, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({q[31:1], perr}, 32'h1);
        for (r = 0; r < 4; r++) begin
            // digital filter always on: the block only runs hybrid mode
            ctrl = 32'($random(seed)) & 32'h0000007F;
            if (r == 1) ctrl[6:2] = 5'h1F;
            // corners: fifo and averaging on, then both off with unit zero
            if (r == 2) ctrl[1:0] = 2'h3;
            if (r == 3) ctrl[4:0] = 5'h00;
            m = 2'($random(seed));
            if (r > 1) m = (r == 2) ? 2'h3 : 2'h0;
            g = (r == 0) ? 4'h8 : 4'($unsigned($random(seed)) % 9);
            base = 12'($random(seed)) & 12'hFF0;
            nch = ctrl[6:5] + 1;
            cnt = 1 << ctrl[3:2];
            apb(1'b1, `HBS_OFS_CTRL, ctrl);
            apb(1'b1, `HBS_OFS_IRQ_MASK, {30'h0, m});
            if (r[0]) begin
                apb(1'b1, `HBS_OFS_CMD, {24'h0, g, 4'h1});
            end else begin
                periph_trig[g] <= 1'b1;
                @(posedge clock);
                periph_trig <= 9'h000;
            end
            s0 = samples;
            apb(1'b0, `HBS_OFS_STATE, 32'h0);
            chk(q, (32'h1 << g) | (32'h1 << (16 + ctrl[4])));
            chk({31'h0, conv_unit}, {31'h0, ctrl[4]});
            apb(1'b1, `HBS_OFS_CMD, {24'h0, g, 4'h1});
            apb(1'b0, `HBS_OFS_IRQ_STAT, 32'h0);
            chk(q, 32'h2);
            apb(1'b1, `HBS_OFS_IRQ_STAT, 32'h3);
            n = 0;
            do begin
                apb(1'b0, `HBS_OFS_STATE, 32'h0);
                n++;
            end while (q[24] !== 1'b1 && n < 300);
            chk({q[24], 31'(samples - s0 >= 4 * cnt * nch)}, 32'h80000001);
            check_store();
            base = 12'($random(seed)) & 12'hFF0;
            s0 = samples;
            while (samples < s0 + (5 * cnt + 1) * nch) @(posedge clock);
            check_store();
            apb(1'b1, `HBS_OFS_CMD, 32'h100);
            apb(1'b0, `HBS_OFS_STATE, 32'h0);
            chk(q, 32'h0);
        end
        // reset in the middle of a running scan leaves the block idle
        periph_trig[0] <= 1'b1;
        @(posedge clock);
        periph_trig <= 9'h000;
        repeat (6) @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, `HBS_OFS_STATE, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `HBS_OFS_CTRL, 32'h0);
        chk({q[31:1], irq}, 32'h0);
        wrap_up();
    end
endmodule : tb_hbs_sequencer
`default_nettype wire
